/* File: bench/nand_status_id_param_cmds_tb_top.sv */
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "nfc_map.svh"
`default_nettype none
module nand_status_id_param_cmds_tb_top;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h00000000;
    logic [31:0] seed    = 32'h919CDA62;
    logic [31:0] prdata, rv;
    logic [7:0]  io_out, io_in;
    logic        pready, pslverr, se, ce_n, cle, ale, we_n, re_n;
    logic        wp_n, oe_n, rb_n;
    int          err_total = 0;
    int          check_count = 0;
    always #20 sys_clk = ~sys_clk;
    nfc_host u_dut (.sys_clk(sys_clk), .ce(1'b1), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
        .nand_re_n(re_n), .nand_wp_n(wp_n), .nand_io_out(io_out),
        .nand_io_oe_n(oe_n), .nand_io_in(io_in), .nand_rb_n(rb_n));
    nfc_dev_model u_dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .re_n(re_n), .wp_n(wp_n), .host_io(io_out), .host_oe_n(oe_n),
        .bus(io_in), .rb_n(rb_n));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // expected id summary built from the two id bytes
    function automatic logic [31:0] exp_info(input logic [7:0] b2, b3);
        return {8'h00, b3[7] & ~b3[3], ~b3[6], b3[5:4] == 2'b10,
                b3[1:0] == 2'b10, b2[7], b2[6], b2[3:2] == 2'b00,
                b2[1:0] == 2'b01, b3, b2};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer; holds everything until pready is seen high
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rv = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // launch an op and poll until the sequencer is idle
    task automatic op(input logic [2:0] c);
        bus(`NFC_A_CMD, 1'b1, {29'h0, c});
        do bus(`NFC_A_STAT, 1'b0, 0); while (rv[0] !== 1'b0);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog sized well beyond the sequence below
    initial begin
        #4000000;
        err_total++;
        print_verdict();
    end
    initial begin : main
        logic [11:0] col;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        bus(`NFC_A_STAT, 1'b0, 0);
        chk("sr_reset", {24'h0, rv[15:8]}, 32'h000000E0);
        bus(8'h18, 1'b0, 0);
        chk("unmapped", {31'h0, se}, 32'h1);
        bus(`NFC_A_CTRL, 1'b1, 32'h1);
        // second reset while the first runs is refused
        bus(`NFC_A_CMD, 1'b1, 32'h2);
        bus(`NFC_A_CMD, 1'b1, 32'h2);
        bus(`NFC_A_STAT, 1'b0, 0);
        chk("reset_again", {31'h0, rv[1]}, 32'h1);
        // enhanced status while the reset still runs is refused
        bus(`NFC_A_STAT, 1'b1, 32'h2);
        bus(`NFC_A_CMD, 1'b1, 32'h1);
        bus(`NFC_A_STAT, 1'b0, 0);
        chk("estat_reset", {31'h0, rv[1]}, 32'h1);
        do bus(`NFC_A_STAT, 1'b0, 0); while (rv[0] !== 1'b0);
        bus(`NFC_A_STAT, 1'b1, 32'h2);
        bus(`NFC_A_CMD, 1'b1, 32'h3);
        bus(`NFC_A_STAT, 1'b0, 0);
        chk("param_busy", {31'h0, rv[1]}, 32'h1);
        do bus(`NFC_A_STAT, 1'b0, 0); while (rv[4] !== 1'b0);
        bus(`NFC_A_STAT, 1'b1, 32'h2);
        // status repeats on a later read strobe
        op(3'h0);
        op(3'h6);
        bus(`NFC_A_DATA, 1'b0, 0);
        chk("status_rep", {24'h0, rv[7:0]}, 32'h000000E0);
        for (int i = 0; i < 2; i++) begin
            bus(`NFC_A_CTRL, 1'b1, 32'(1 - i));
            op(3'h0);
            bus(`NFC_A_STAT, 1'b0, 0);
            chk("sr_wp", {24'h0, rv[15:8]}, {24'h0, ~i[0], 7'h60});
        end
        bus(`NFC_A_CTRL, 1'b1, 32'h3);
        bus(`NFC_A_CMD, 1'b1, 32'h0);
        bus(`NFC_A_STAT, 1'b0, 0);
        chk("multi_die", {31'h0, rv[1]}, 32'h1);
        bus(`NFC_A_CTRL, 1'b1, 32'h1);
        bus(`NFC_A_STAT, 1'b1, 32'h2);
        seed = lfsr(seed);
        bus(`NFC_A_ADDR, 1'b1, {8'h0, seed[23:0]});
        op(3'h1);
        bus(`NFC_A_STAT, 1'b0, 0);
        chk("enh_status", {23'h0, rv[15:8], rv[3]}, 32'h1C1);
        op(3'h5);
        bus(`NFC_A_STAT, 1'b0, 0);
        chk("read_mode", {31'h0, rv[1]}, 32'h0);
        op(3'h3);
        for (int k = 0; k < 2; k++) begin
            op(3'h6);
            bus(`NFC_A_DATA, 1'b0, 0);
            chk("param", rv, {24'h0, 8'(k) ^ 8'hA5});
        end
        repeat (4) begin
            seed = lfsr(seed);
            col = seed[11:0];
            bus(`NFC_A_ADDR, 1'b1, {20'h0, col});
            op(3'h4);
            op(3'h6);
            bus(`NFC_A_DATA, 1'b0, 0);
            chk("rand_out", rv, {24'h0, col[7:0] ^ 8'hA5});
            op(3'h0);
            op(3'h5);
            op(3'h6);
            bus(`NFC_A_DATA, 1'b0, 0);
            chk("resume", rv, {24'h0, (col[7:0] + 8'h01) ^ 8'hA5});
        end
        op(3'h7);
        bus(`NFC_A_IDINFO, 1'b0, 0);
        chk("id_info", rv, exp_info(8'hD1, 8'hA2));
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: bench/nfc_dev_model.sv */
// behavioural flash device answering status, id and parameter commands
`timescale 1ns/1ps
`default_nettype none
module nfc_dev_model #(
    parameter int         BUSY_NS  = 2000,
    parameter logic [7:0] MFR_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h4B  // arbitrary value
) (
    input  wire logic       ce_n,
    input  wire logic       cle,
    input  wire logic       ale,
    input  wire logic       we_n,
    input  wire logic       re_n,
    input  wire logic       wp_n,
    input  wire logic [7:0] host_io,
    input  wire logic       host_oe_n,
    output logic      [7:0] bus,
    output var logic        rb_n
);
    logic [7:0]  mode   = 8'h00;
    logic [7:0]  dmode  = 8'h00;
    logic [7:0]  dout   = 8'h00;
    logic [15:0] colbuf = 16'h0000;
    logic [11:0] ptr    = 12'h000;
    initial rb_n = 1'b1;
    // commands latch on the rising write strobe, addresses shift in
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            case (host_io)
                8'h70, 8'h78: mode <= host_io;
                8'hFF: if (rb_n) begin
                    mode <= 8'h00;
                    rb_n <= #20 1'b0;
                    rb_n <= #(BUSY_NS) 1'b1;
                end
                8'hEC: if (rb_n) begin
                    mode  <= 8'hEC;
                    dmode <= 8'hEC;
                    ptr   <= 12'h000;
                    rb_n  <= #20 1'b0;
                    rb_n  <= #(BUSY_NS / 4) 1'b1;
                end
                8'h90: begin
                    mode <= 8'h90;
                    ptr  <= 12'h000;
                end
                8'h00: if (rb_n) mode <= dmode;
                8'hE0: begin
                    mode <= dmode;
                    ptr  <= colbuf[11:0];
                end
                default: ;
            endcase
        end else if (!ce_n && ale) colbuf <= {host_io, colbuf[15:8]};
    end
    // one byte per falling read strobe
    always @(negedge re_n) begin
        if (!ce_n) begin
            case (mode)
                8'h70, 8'h78: dout <= {wp_n, rb_n, rb_n, 5'h00};
                // copies repeat every 256 bytes
                // status reads leave the data pointer where it was
                8'hEC: begin
                    dout <= ptr[7:0] ^ 8'hA5;
                    ptr  <= ptr + 12'h001;
                end
                8'h90: begin
                    case (ptr[1:0])
                        2'h0: dout <= MFR_CODE;
                        2'h1: dout <= DEV_CODE;
                        2'h2: dout <= {1'b1, 1'b1, 2'b01, 2'b00, 2'b01};
                        default: dout <= {1'b1, 1'b0, 2'b10, 1'b0, 1'b0,
                                          2'b10};
                    endcase
                    ptr <= ptr + 12'h001;
                end
                default: ;
            endcase
        end
    end
    // released bus shows the inverse so a late sample is caught
    assign bus = !host_oe_n ? host_io :
                 (!ce_n && !re_n && mode != 8'h00) ? dout : ~dout;
endmodule
`default_nettype wire

/* File: src/nfc_host.sv */
// apb-controlled host sequencer for status, id and parameter page commands
//
// Functional notes
// - status byte read after status command
// - no plain status during interleaved operation
// - enhanced status: command plus three rows
// - no enhanced status during reset
// - read mode only after die ready
// - parameter page: command and zero address
// - parameter page only when all ready
// - random data out moves output pointer
// - status poll then read mode resumes
`timescale 1ns/1ps
`include "nfc_map.svh"
`default_nettype none
module nfc_host (
    input  wire logic        sys_clk,
    input  wire logic        ce,
    input  wire logic        rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             nand_ce_n,
    output logic             nand_cle,
    output logic             nand_ale,
    output logic             nand_we_n,
    output logic             nand_re_n,
    output logic             nand_wp_n,
    output logic      [7:0]  nand_io_out,
    output logic             nand_io_oe_n,
    input  wire logic [7:0]  nand_io_in,
    input  wire logic        nand_rb_n
);
    localparam logic [3:0] WP_LOW = 4'(`NFC_WP_CYC);
    localparam logic [3:0] W_END  = 4'(2 * `NFC_WP_CYC - 1);
    localparam logic [3:0] R_LOW  = 4'(`NFC_RD_CYC);
    localparam logic [3:0] R_CAP  = 4'(`NFC_RD_CYC - 1);
    localparam logic [3:0] R_END  = 4'(`NFC_RD_CYC + `NFC_WP_CYC - 1);
    localparam logic [3:0] WB_END = 4'(`NFC_WB_CYC - 1);

    nfc_pkg::nfc_st_t state_r, state_nxt, after_cmd1, after_addr;
    nfc_pkg::nfc_st_t after_cmd2, after_wait, start_st;
    nfc_pkg::nfc_op_t op_r, op_sel;
    logic [3:0]  cnt_r, cnt_nxt, rst_wb_r;
    logic [1:0]  step_r, step_nxt, nadr;
    logic [2:0]  nread;
    logic [7:0]  cmd1_byte, io_s, status_r, data_r, id2_r, id3_r;
    logic [23:0] addr_r;
    logic [1:0]  ctrl_r;
    logic [8:0]  pins_s;
    logic        has_cmd1, has_cmd2, has_wait, uses_addr, rb_s;
    logic        acc, wr_acc, hit, cmd_wr, refuse, launch, cap;
    logic        mode_r, err_r, rst_busy_r;
    logic [31:0] rd_mux;

    nfc_sync u_sync (
        .sys_clk  (sys_clk),
        .ce       (ce),
        .rst      (rst),
        .async_in ({~nand_rb_n, nand_io_in}),
        .sync_out (pins_s)
    );
    assign io_s = pins_s[7:0];
    assign rb_s = ~pins_s[8];

    // apb slave: zero wait states, unmapped offsets answer with pslverr
    assign acc    = psel & penable;
    assign wr_acc = acc & pwrite & ce;
    assign hit    = (paddr == `NFC_A_CMD) || (paddr == `NFC_A_ADDR) ||
                    (paddr == `NFC_A_CTRL) || (paddr == `NFC_A_STAT) ||
                    (paddr == `NFC_A_DATA) || (paddr == `NFC_A_IDINFO);
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;
    assign cmd_wr  = wr_acc & (paddr == `NFC_A_CMD);
    assign op_sel  = (state_r == nfc_pkg::ST_IDLE) ?
                     nfc_pkg::nfc_op_t'(pwdata[2:0]) : op_r;

    // read mux, with decoded id fields for software
    always_comb begin
        rd_mux = 32'h0;
        case (paddr)
            `NFC_A_ADDR: rd_mux = {8'h0, addr_r};
            `NFC_A_CTRL: rd_mux = {30'h0, ctrl_r};
            `NFC_A_STAT: rd_mux = {16'h0, status_r, 3'h0, rst_busy_r,
                                   mode_r, rb_s, err_r,
                                   state_r != nfc_pkg::ST_IDLE};
            `NFC_A_DATA: rd_mux = {24'h0, data_r};
            `NFC_A_IDINFO: rd_mux = {8'h0,
                id3_r[7] & ~id3_r[3], ~id3_r[6],
                id3_r[5:4] == `NFC_ID_BLK256, id3_r[1:0] == `NFC_ID_PG4K,
                id2_r[7], id2_r[6], id2_r[3:2] == `NFC_ID_SLC,
                id2_r[1:0] == `NFC_ID_TWO_DIE, id3_r, id2_r};
            default: rd_mux = 32'h0;
        endcase
    end

    // read data is registered in the setup cycle, stable in access
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // software registers: address and control
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_r <= 24'h0;
            ctrl_r <= `NFC_CTRL_RST;
        end else if (wr_acc && paddr == `NFC_A_ADDR) begin
            addr_r <= pwdata[23:0];
        end else if (wr_acc && paddr == `NFC_A_CTRL) begin
            ctrl_r <= pwdata[1:0];
        end
    end
    assign nand_wp_n = ctrl_r[`NFC_CTRL_WPN];

    // per-operation bus sequence
    always_comb begin
        has_cmd1  = 1'b1;
        cmd1_byte = `NFC_C_STATUS;
        nadr      = 2'd0;
        has_cmd2  = 1'b0;
        has_wait  = 1'b0;
        nread     = 3'd0;
        uses_addr = 1'b0;
        case (op_sel)
            nfc_pkg::OP_STATUS: nread = 3'd1;
            nfc_pkg::OP_ESTATUS: begin
                cmd1_byte = `NFC_C_ESTATUS;
                nadr      = 2'd3;
                nread     = 3'd1;
                uses_addr = 1'b1;
            end
            nfc_pkg::OP_RESET: cmd1_byte = `NFC_C_RESET;
            nfc_pkg::OP_PARAM: begin
                cmd1_byte = `NFC_C_PARAM;
                nadr      = 2'd1;
                has_wait  = 1'b1;
            end
            // column pair between 05h and E0h
            nfc_pkg::OP_RANDOUT: begin
                cmd1_byte = `NFC_C_RAND1;
                nadr      = 2'd2;
                has_cmd2  = 1'b1;
                uses_addr = 1'b1;
            end
            nfc_pkg::OP_READMODE: cmd1_byte = `NFC_C_READMODE;
            nfc_pkg::OP_READ: begin
                has_cmd1 = 1'b0;
                nread    = 3'd1;
            end
            nfc_pkg::OP_ID: begin
                cmd1_byte = `NFC_C_ID;
                nadr      = 2'd1;
                nread     = 3'd4;
            end
            default: has_cmd1 = 1'b0;
        endcase
        after_wait = (nread != 3'd0) ? nfc_pkg::ST_READ : nfc_pkg::ST_IDLE;
        after_cmd2 = has_wait ? nfc_pkg::ST_WB : after_wait;
        after_addr = has_cmd2 ? nfc_pkg::ST_CMD2 : after_cmd2;
        after_cmd1 = (nadr != 2'd0) ? nfc_pkg::ST_ADDR : after_addr;
        start_st   = has_cmd1 ? nfc_pkg::ST_CMD1 : after_cmd1;
    end

    // launch checks: ops the device would not accept are refused
    always_comb begin
        refuse = 1'b0;
        case (op_sel)
            nfc_pkg::OP_STATUS:   refuse = ctrl_r[`NFC_CTRL_MULTI];
            nfc_pkg::OP_ESTATUS:  refuse = rst_busy_r;
            nfc_pkg::OP_RESET:    refuse = rst_busy_r;
            nfc_pkg::OP_PARAM:    refuse = ~rb_s | rst_busy_r;
            // data out only after ready status
            nfc_pkg::OP_READMODE: refuse = mode_r & ~status_r[`NFC_SR_CACHE];
            default:              refuse = 1'b0;
        endcase
    end
    assign launch = cmd_wr && (state_r == nfc_pkg::ST_IDLE) && !refuse;

    // sequencer next state: one byte per strobe period
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 4'd1;
        step_nxt  = step_r;
        case (state_r)
            nfc_pkg::ST_IDLE: begin
                cnt_nxt  = 4'd0;
                step_nxt = 2'd0;
                if (launch) begin
                    state_nxt = start_st;
                end
            end
            nfc_pkg::ST_CMD1: if (cnt_r == W_END) begin
                cnt_nxt   = 4'd0;
                state_nxt = after_cmd1;
            end
            nfc_pkg::ST_ADDR: if (cnt_r == W_END) begin
                cnt_nxt  = 4'd0;
                step_nxt = step_r + 2'd1;
                if (step_r == nadr - 2'd1) begin
                    step_nxt  = 2'd0;
                    state_nxt = after_addr;
                end
            end
            nfc_pkg::ST_CMD2: if (cnt_r == W_END) begin
                cnt_nxt   = 4'd0;
                state_nxt = after_cmd2;
            end
            // ready pin is stale until tWB has passed
            nfc_pkg::ST_WB: if (cnt_r == WB_END) begin
                cnt_nxt   = 4'd0;
                state_nxt = nfc_pkg::ST_BUSY;
            end
            nfc_pkg::ST_BUSY: begin
                cnt_nxt = 4'd0;
                if (rb_s) begin
                    state_nxt = after_wait;
                end
            end
            nfc_pkg::ST_READ: if (cnt_r == R_END) begin
                cnt_nxt  = 4'd0;
                step_nxt = step_r + 2'd1;
                if (step_r == 2'(nread - 3'd1)) begin
                    step_nxt  = 2'd0;
                    state_nxt = nfc_pkg::ST_IDLE;
                end
            end
            default: state_nxt = nfc_pkg::ST_IDLE;
        endcase
    end

    // sequencer state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= nfc_pkg::ST_IDLE;
            op_r    <= nfc_pkg::OP_STATUS;
            cnt_r   <= 4'd0;
            step_r  <= 2'd0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            step_r  <= step_nxt;
            if (launch) begin
                op_r <= op_sel;
            end
        end
    end

    // pins registered from next state so strobes never glitch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nand_ce_n    <= 1'b1;
            nand_cle     <= 1'b0;
            nand_ale     <= 1'b0;
            nand_we_n    <= 1'b1;
            nand_re_n    <= 1'b1;
            nand_io_oe_n <= 1'b1;
            nand_io_out  <= 8'h00;
        end else if (ce) begin
            nand_ce_n <= state_nxt == nfc_pkg::ST_IDLE;
            nand_cle  <= state_nxt == nfc_pkg::ST_CMD1 ||
                         state_nxt == nfc_pkg::ST_CMD2;
            nand_ale  <= state_nxt == nfc_pkg::ST_ADDR;
            nand_we_n <= !((state_nxt == nfc_pkg::ST_CMD1 ||
                            state_nxt == nfc_pkg::ST_ADDR ||
                            state_nxt == nfc_pkg::ST_CMD2) &&
                           cnt_nxt < WP_LOW);
            nand_re_n <= !(state_nxt == nfc_pkg::ST_READ && cnt_nxt < R_LOW);
            // bus released during reads so the die can drive it
            nand_io_oe_n <= !(state_nxt == nfc_pkg::ST_CMD1 ||
                              state_nxt == nfc_pkg::ST_ADDR ||
                              state_nxt == nfc_pkg::ST_CMD2);
            case (state_nxt)
                nfc_pkg::ST_CMD1: nand_io_out <= cmd1_byte;
                nfc_pkg::ST_CMD2: nand_io_out <= `NFC_C_RAND2;
                nfc_pkg::ST_ADDR: nand_io_out <= uses_addr ?
                    addr_r[{step_nxt, 3'b000} +: 8] : `NFC_ADDR_ZERO;
                default: nand_io_out <= nand_io_out;
            endcase
        end
    end

    // capture of read bytes; status mode persists across plain reads
    assign cap = ce && state_r == nfc_pkg::ST_READ && cnt_r == R_CAP;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_r <= `NFC_SR_RST;
            data_r   <= 8'h00;
            id2_r    <= 8'h00;
            id3_r    <= 8'h00;
        end else if (cap) begin
            data_r <= io_s;
            if (op_r == nfc_pkg::OP_STATUS || op_r == nfc_pkg::OP_ESTATUS ||
                (op_r == nfc_pkg::OP_READ && mode_r)) begin
                status_r <= io_s;
            end
            if (op_r == nfc_pkg::OP_ID && step_r == 2'd2) begin
                id2_r <= io_s;
            end
            if (op_r == nfc_pkg::OP_ID && step_r == 2'd3) begin
                id3_r <= io_s;
            end
        end
    end

    // output mode tracking of the device
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_r <= 1'b0;
        end else if (ce && launch && op_sel != nfc_pkg::OP_READ) begin
            mode_r <= op_sel == nfc_pkg::OP_STATUS ||
                      op_sel == nfc_pkg::OP_ESTATUS;
        end
    end

    // reset in progress until tWB passed and ready
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rst_busy_r <= 1'b0;
            rst_wb_r   <= 4'd0;
        end else if (ce) begin
            if (state_r == nfc_pkg::ST_CMD1 && op_r == nfc_pkg::OP_RESET &&
                cnt_r == W_END) begin
                rst_busy_r <= 1'b1;
                rst_wb_r   <= WB_END;
            end else if (rst_wb_r != 4'd0) begin
                rst_wb_r <= rst_wb_r - 4'd1;
            end else if (rb_s) begin
                rst_busy_r <= 1'b0;
            end
        end
    end

    // refusal flag: set beats a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            err_r <= 1'b0;
        end else if (cmd_wr && !launch) begin
            err_r <= 1'b1;
        end else if (wr_acc && paddr == `NFC_A_STAT && pwdata[`NFC_ST_ERR]) begin
            err_r <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_status_cmd;
        state_r == nfc_pkg::ST_CMD1 && op_r == nfc_pkg::OP_STATUS && !nand_we_n
        |-> nand_cle && !nand_ale && !nand_io_oe_n &&
            nand_io_out == `NFC_C_STATUS;
    endproperty
    a_status_cmd: assert property (p_status_cmd)
        else $error("status command byte wrong");

    property p_status_repeat;
        cap && mode_r && op_r == nfc_pkg::OP_READ
        |=> status_r == $past(io_s);
    endproperty
    a_status_repeat: assert property (p_status_repeat)
        else $error("status not refreshed on read");

    property p_plain_refused;
        cmd_wr && state_r == nfc_pkg::ST_IDLE && ctrl_r[`NFC_CTRL_MULTI] &&
        op_sel == nfc_pkg::OP_STATUS |=> err_r && state_r == nfc_pkg::ST_IDLE;
    endproperty
    a_plain_refused: assert property (p_plain_refused)
        else $error("plain status issued while interleaving");

    property p_estat_rows;
        $rose(nand_ale) && op_r == nfc_pkg::OP_ESTATUS
        |-> nand_io_out == addr_r[7:0] ##1 (step_r == 2'd0)[*1];
    endproperty
    a_estat_rows: assert property (p_estat_rows)
        else $error("enhanced status row byte wrong");

    property p_estat_no_reset;
        cmd_wr && rst_busy_r && op_sel == nfc_pkg::OP_ESTATUS
        |=> state_r == nfc_pkg::ST_IDLE && err_r;
    endproperty
    a_estat_no_reset: assert property (p_estat_no_reset)
        else $error("enhanced status during reset");

    property p_readmode;
        state_r == nfc_pkg::ST_CMD1 && op_r == nfc_pkg::OP_READMODE &&
        !nand_we_n |-> nand_io_out == `NFC_C_READMODE && nand_cle;
    endproperty
    a_readmode: assert property (p_readmode)
        else $error("read mode byte wrong");

    property p_reset_once;
        cmd_wr && rst_busy_r && op_sel == nfc_pkg::OP_RESET
        |=> state_r == nfc_pkg::ST_IDLE;
    endproperty
    a_reset_once: assert property (p_reset_once)
        else $error("second reset issued");

    property p_param_ready;
        state_r == nfc_pkg::ST_CMD1 && $past(state_r) == nfc_pkg::ST_IDLE &&
        op_r == nfc_pkg::OP_PARAM |-> $past(rb_s);
    endproperty
    a_param_ready: assert property (p_param_ready)
        else $error("parameter page while busy");

    property p_rand_pair;
        state_r == nfc_pkg::ST_CMD2 && !nand_we_n
        |-> op_r == nfc_pkg::OP_RANDOUT && nand_io_out == `NFC_C_RAND2;
    endproperty
    a_rand_pair: assert property (p_rand_pair)
        else $error("random out closing byte wrong");

    c_status: cover property (cap && op_r == nfc_pkg::OP_STATUS);
    c_estat: cover property (cap && op_r == nfc_pkg::OP_ESTATUS);
    c_param: cover property (state_r == nfc_pkg::ST_BUSY ##1
                             state_r == nfc_pkg::ST_IDLE);
    c_id: cover property (cap && op_r == nfc_pkg::OP_ID && step_r == 2'd3);
endmodule
`default_nettype wire

/* File: src/nfc_map.svh */
// register offsets, command codes, field positions and timing counts
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH

// register byte offsets on the apb side
`define NFC_A_CMD       8'h00
`define NFC_A_ADDR      8'h04
`define NFC_A_CTRL      8'h08
`define NFC_A_STAT      8'h0C
`define NFC_A_DATA      8'h10
`define NFC_A_IDINFO    8'h14

// reset values of software-visible registers
`define NFC_CTRL_RST    2'h0
`define NFC_SR_RST      8'hE0

// command codes sent on the flash bus
`define NFC_C_STATUS    8'h70
`define NFC_C_ESTATUS   8'h78
`define NFC_C_RESET     8'hFF
`define NFC_C_PARAM     8'hEC
`define NFC_C_RAND1     8'h05
`define NFC_C_RAND2     8'hE0
`define NFC_C_READMODE  8'h00
`define NFC_C_ID        8'h90
`define NFC_ADDR_ZERO   8'h00

// control register bits
`define NFC_CTRL_WPN    0
`define NFC_CTRL_MULTI  1

// status register bits
`define NFC_ST_BUSY     0
`define NFC_ST_ERR      1
`define NFC_ST_RB       2
`define NFC_ST_SMODE    3
`define NFC_ST_RSTBUSY  4
`define NFC_ST_SR_LSB   8

// device status byte bit positions
`define NFC_SR_FAIL     0
`define NFC_SR_PREV     1
`define NFC_SR_ARRAY    5
`define NFC_SR_CACHE    6
`define NFC_SR_WPN      7

// extended id byte field values
`define NFC_ID_TWO_DIE  2'h1
`define NFC_ID_SLC      2'h0
`define NFC_ID_PG4K     2'h2
`define NFC_ID_BLK256   2'h2

// timing: clock period and flash times in ns, cycle counts derived
`define NFC_CLK_NS      40
`define NFC_T_WP_NS     25
`define NFC_T_REA_NS    20
`define NFC_T_WB_NS     100
`define NFC_SYNC_STAGES 2
`define NFC_WP_CYC  ((`NFC_T_WP_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_RD_CYC  (((`NFC_T_REA_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS) + `NFC_SYNC_STAGES)
`define NFC_WB_CYC  ((`NFC_T_WB_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

/* File: src/nfc_pkg.sv */
// types shared by the flash host controller
package nfc_pkg;
    typedef enum logic [2:0] {
        OP_STATUS   = 3'b000,
        OP_ESTATUS  = 3'b001,
        OP_RESET    = 3'b010,
        OP_PARAM    = 3'b011,
        OP_RANDOUT  = 3'b100,
        OP_READMODE = 3'b101,
        OP_READ     = 3'b110,
        OP_ID       = 3'b111
    } nfc_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD1 = 3'b001,
        ST_ADDR = 3'b010,
        ST_CMD2 = 3'b011,
        ST_WB   = 3'b100,
        ST_BUSY = 3'b101,
        ST_READ = 3'b110
    } nfc_st_t;
endpackage

/* File: src/nfc_sync.sv */
// two-flop synchroniser for the flash pins read by the controller
`timescale 1ns/1ps
`default_nettype none
module nfc_sync (
    input  wire logic       sys_clk,
    input  wire logic       ce,
    input  wire logic       rst,
    input  wire logic [8:0] async_in,
    output logic      [8:0] sync_out
);
    logic [8:0] meta_r;

    // one chain per bit; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < 9; i = i + 1) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    meta_r[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else if (ce) begin
                    meta_r[i]   <= async_in[i];
                    sync_out[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire
